// *** pkg/dps_pkg.sv ***
// Overview of operation
// R1: read data leaves on serial clock falling edges
// R2: master drives input; device samples rising edges
// R3: hold low while clock low pauses
// R4: hold high while clock low resumes
// R5: pause keeps bit count and bytes
// R6: hold stays high when pause unused
// R7: strap pins form 4-bit slave address; only bits 1:0 come from straps here, bits 3:2 are fixed at ADDR_HI
// R8: act only when streamed address matches straps
// R9: chip select high deselects, output released
// R10: deselected means standby unless write busy
// R11: chip select low enables, awaits command
// R12: ignore bus until first select fall
// R13: power-up copies default register into wiper
// R14: one volatile wiper register per pot
// R15: four writable readable data registers per pot
// R16: wiper selects one of 256 taps
// R17: first byte: type code, then address
// R18: second byte: opcode, register, pot select
// R19: write protect low refuses data writes
// R20: busy flag high during nonvolatile write
// R21: while paused, no sampling, output released
package dps_pkg;
   // device type code: arbitrary value
   localparam logic [3:0]  DEV_TYPE      = 4'hA;
   localparam logic [1:0]  ADDR_HI       = 2'h0;
   localparam logic [3:0]  OP_RD_WIPER   = 4'h9;
   localparam logic [3:0]  OP_WR_WIPER   = 4'hA;
   localparam logic [3:0]  OP_RD_DATA    = 4'hB;
   localparam logic [3:0]  OP_WR_DATA    = 4'hC;
   localparam logic [3:0]  OP_RD_STATUS  = 4'h5;
   localparam logic [1:0]  DEFAULT_REG   = 2'h0;
   localparam logic [7:0]  DATA_RESET    = 8'h80;
   localparam int          CLK_MHZ       = 200;
   localparam int          NV_WRITE_MS   = 10;
   localparam int          NV_WRITE_CYC  = NV_WRITE_MS * CLK_MHZ * 1000;
   localparam int          NV_CNT_W      = 22;
   localparam logic [4:0]  SCK_DIV_LAST  = 5'h0F;
   localparam logic [4:0]  BITS_LAST     = 5'h17;
   localparam logic [3:0]  REG_CMD       = 4'h0;
   localparam logic [3:0]  REG_TXD       = 4'h4;
   localparam logic [3:0]  REG_STATUS    = 4'h8;
   localparam logic [3:0]  REG_HOLD      = 4'hC;
   localparam int          CMD_ADDR_LSB  = 0;
   localparam int          CMD_OP_LSB    = 8;
   localparam int          CMD_SEL_LSB   = 12;
   localparam int          CMD_POT_BIT   = 14;
   localparam int          STAT_BUSY_BIT = 0;
   localparam int          STAT_HELD_BIT = 1;
   localparam int          STAT_RX_LSB   = 8;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_ID     = 3'h1,
      ST_INSTR  = 3'h2,
      ST_DATA   = 3'h3,
      ST_IGNORE = 3'h4
   } dps_dev_st_t;

   typedef enum logic [2:0] {
      H_IDLE  = 3'h0,
      H_SETUP = 3'h1,
      H_RUN   = 3'h2,
      H_DONE  = 3'h3,
      H_GAP   = 3'h4
   } dps_host_st_t;
endpackage

// *** pkg/dps_spi_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dps_spi_if;
   logic cs_b;
   logic sck;
   logic mosi;
   logic hold_b;
   logic miso;
   logic miso_oe_b;
   logic miso_line;

   // released output reads as pulled high
   assign miso_line = miso_oe_b ? 1'b1 : miso;

   modport device (input cs_b, input sck, input mosi, input hold_b,
                   output miso, output miso_oe_b);
   modport host (output cs_b, output sck, output mosi, output hold_b,
                 input miso_line);
endinterface
`default_nettype wire

// *** rtl/dps_device.sv ***
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dps_device #(
   parameter int NV_WRITE_CYC = dps_pkg::NV_WRITE_CYC
) (
   input  wire logic        REF_CLK,     // 200 MHz clock
   input  wire logic        RST_B,       // async reset, power-up
   dps_spi_if.device        SPI,         // serial port pins
   input  wire logic        SLAVE_ADDR_STRAP_0, // address strap bit 0
   input  wire logic        SLAVE_ADDR_STRAP_1, // address strap bit 1
   input  wire logic        WP_B,        // write protect, low refuses
   output wire logic [1:0][7:0] WIPER_POS, // wiper position per pot
   output wire logic        NV_WRITE_BUSY, // nonvolatile write running
   output wire logic        STANDBY      // standby power state
);
   typedef struct packed {
      logic [1:0]                cs_y;
      logic [1:0]                sck_y;
      logic [1:0]                si_y;
      logic [1:0]                hold_y;
      logic [1:0]                wp_y;
      logic [1:0]                a0_y;
      logic [1:0]                a1_y;
      logic                      sck_p;
      logic                      cs_p;
      logic                      held;
      logic                      recalled;
      dps_pkg::dps_dev_st_t      st;
      logic [2:0]                cnt;
      logic [7:0]                rx;
      logic [3:0]                op;
      logic [1:0]                sel;
      logic                      pot;
      logic                      rd;
      logic [7:0]                tx;
      logic                      so;
      logic                      drive;
      logic [1:0][7:0]           wiper_position_reg;
      logic [1:0][3:0][7:0]      data_reg;
      logic [dps_pkg::NV_CNT_W-1:0] busy_cnt;
   } dps_dev_t;

   dps_dev_t q;
   dps_dev_t d;

   logic       cs_s;
   logic       sck_s;
   logic       si_s;
   logic       hold_s;
   logic       rise;
   logic       fall;
   logic       busy;
   logic [3:0] own_addr;
   logic [7:0] byte_in;

   assign cs_s     = q.cs_y[1];
   assign sck_s    = q.sck_y[1];
   assign si_s     = q.si_y[1];
   assign hold_s   = q.hold_y[1];
   assign rise     = sck_s & ~q.sck_p;
   assign fall     = ~sck_s & q.sck_p;
   assign busy     = (q.busy_cnt != '0);
   assign own_addr = {dps_pkg::ADDR_HI, q.a1_y[1], q.a0_y[1]}; // [R7]
   assign byte_in  = {q.rx[6:0], si_s};

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      d = q;
      d.cs_y   = {q.cs_y[0], SPI.cs_b};
      d.sck_y  = {q.sck_y[0], SPI.sck};
      d.si_y   = {q.si_y[0], SPI.mosi};
      d.hold_y = {q.hold_y[0], SPI.hold_b};
      d.wp_y   = {q.wp_y[0], WP_B};
      d.a0_y   = {q.a0_y[0], SLAVE_ADDR_STRAP_0};
      d.a1_y   = {q.a1_y[0], SLAVE_ADDR_STRAP_1};
      d.sck_p  = sck_s;
      d.cs_p   = cs_s;
      if (busy)
      begin
         d.busy_cnt = q.busy_cnt - 1'b1;
      end
      if (!q.recalled)
      begin
         d.recalled = 1'b1;
         for (int p = 0; p < 2; p++)
         begin
            d.wiper_position_reg[p] = q.data_reg[p][dps_pkg::DEFAULT_REG]; // [R13] [R14]
         end
      end
      if (cs_s)
      begin
         // deselected: sequence dropped, output released
         d.st    = dps_pkg::ST_IDLE; // [R9]
         d.cnt   = 3'h0;
         d.held  = 1'b0;
         d.rd    = 1'b0;
         d.drive = 1'b0; // [R9]
      end
      else if (q.cs_p)
      begin
         // only a seen high-to-low edge opens a sequence
         d.st    = dps_pkg::ST_ID; // [R11] [R12]
         d.cnt   = 3'h0;
         d.held  = 1'b0;
      end
      else
      begin
         if (!sck_s)
         begin
            d.held = ~hold_s; // [R3] [R4]
         end
         // pause freezes count, bytes and output shift
         if (!q.held && rise && q.st != dps_pkg::ST_IDLE && q.st != dps_pkg::ST_IGNORE) // [R5] [R21]
         begin
            d.rx  = byte_in; // [R2]
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7)
            begin
               case (q.st)
                  dps_pkg::ST_ID:
                  begin
                     if (byte_in[7:4] == dps_pkg::DEV_TYPE && byte_in[3:0] == own_addr) // [R8] [R17]
                     begin
                        d.st = dps_pkg::ST_INSTR;
                     end
                     else
                     begin
                        d.st = dps_pkg::ST_IGNORE;
                     end
                  end
                  dps_pkg::ST_INSTR:
                  begin
                     d.op  = byte_in[7:4]; // [R18]
                     d.sel = byte_in[3:2];
                     d.pot = byte_in[0];
                     d.st  = dps_pkg::ST_DATA;
                     d.rd  = 1'b1;
                     case (byte_in[7:4])
                        dps_pkg::OP_RD_WIPER:  d.tx = q.wiper_position_reg[byte_in[0]];
                        dps_pkg::OP_RD_DATA:   d.tx = q.data_reg[byte_in[0]][byte_in[3:2]]; // [R15]
                        dps_pkg::OP_RD_STATUS: d.tx = {7'h00, busy}; // [R20]
                        dps_pkg::OP_WR_WIPER:  d.rd = 1'b0;
                        dps_pkg::OP_WR_DATA:   d.rd = 1'b0;
                        default:
                        begin
                           d.rd = 1'b0;
                           d.st = dps_pkg::ST_IGNORE;
                        end
                     endcase
                  end
                  dps_pkg::ST_DATA:
                  begin
                     d.st    = dps_pkg::ST_IGNORE;
                     d.rd    = 1'b0;
                     d.drive = 1'b0;
                     case (q.op)
                        dps_pkg::OP_WR_WIPER:
                        begin
                           d.wiper_position_reg[q.pot] = byte_in; // [R14] [R16]
                        end
                        dps_pkg::OP_WR_DATA:
                        begin
                           if (q.wp_y[1] && !busy) // [R19]
                           begin
                              d.data_reg[q.pot][q.sel] = byte_in; // [R15]
                              d.busy_cnt = dps_pkg::NV_CNT_W'(NV_WRITE_CYC); // [R20]
                           end
                        end
                        default:
                        begin
                           d.drive = 1'b0;
                        end
                     endcase
                  end
                  default:
                  begin
                     d.st = dps_pkg::ST_IGNORE;
                  end
               endcase
            end
         end
         if (!q.held && fall && q.rd)
         begin
            d.drive = 1'b1;
            d.so    = q.tx[7]; // [R1]
            d.tx    = {q.tx[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         q          <= '0;
         q.st       <= dps_pkg::ST_IDLE;
         q.data_reg <= {8{dps_pkg::DATA_RESET}};
      end
      else
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   for (genvar g = 0; g < 2; g++)
   begin : g_pot
      assign WIPER_POS[g] = q.wiper_position_reg[g];
   end

   assign SPI.miso      = q.so;
   assign SPI.miso_oe_b = ~(q.drive & ~q.held & ~cs_s); // [R9] [R21]
   assign NV_WRITE_BUSY = busy; // [R20]
   assign STANDBY       = cs_s & ~busy; // [R10]
endmodule
`default_nettype wire

// *** rtl/dps_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module dps_host (
   input  wire logic        REF_CLK,         // 200 MHz clock
   input  wire logic        RST_B,           // async reset
   dps_spi_if.host          SPI,             // serial port pins
   input  wire logic [3:0]  AVS_ADDRESS,     // byte address
   input  wire logic        AVS_READ,        // read request
   input  wire logic        AVS_WRITE,       // write request
   input  wire logic [31:0] AVS_WRITEDATA,   // write data
   output wire logic [31:0] AVS_READDATA,    // read data
   output wire logic        AVS_WAITREQUEST  // stall
);
   typedef struct packed {
      logic [1:0]            miso_y;
      dps_pkg::dps_host_st_t st;
      logic [4:0]            div;
      logic [4:0]            bitn;
      logic                  sck;
      logic                  cs_b;
      logic                  mosi;
      logic                  hold_b;
      logic [23:0]           sh;
      logic [7:0]            rx;
      logic [3:0]            addr;
      logic [3:0]            op;
      logic [1:0]            sel;
      logic                  pot;
      logic [7:0]            txd;
      logic                  hold_req;
      logic                  rd_ack;
      logic [31:0]           rdata;
   } dps_host_t;

   dps_host_t q;
   dps_host_t d;

   logic busy;
   logic tick;
   logic wr_ok;

   assign busy  = (q.st != dps_pkg::H_IDLE);
   assign tick  = (q.div == dps_pkg::SCK_DIV_LAST);
   assign AVS_WAITREQUEST = (AVS_READ & ~q.rd_ack)
                          | (AVS_WRITE & AVS_ADDRESS == dps_pkg::REG_CMD & busy);
   assign wr_ok = AVS_WRITE & ~AVS_WAITREQUEST;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      d = q;
      d.miso_y = {q.miso_y[0], SPI.miso_line};
      d.rd_ack = AVS_READ & ~q.rd_ack;
      if (AVS_READ && !q.rd_ack)
      begin
         d.rdata = 32'h0000_0000;
         case (AVS_ADDRESS)
            dps_pkg::REG_TXD:
            begin
               d.rdata[7:0] = q.txd;
            end
            dps_pkg::REG_STATUS:
            begin
               d.rdata[dps_pkg::STAT_BUSY_BIT] = busy;
               d.rdata[dps_pkg::STAT_HELD_BIT] = ~q.hold_b;
               d.rdata[dps_pkg::STAT_RX_LSB +: 8] = q.rx;
            end
            dps_pkg::REG_HOLD:
            begin
               d.rdata[0] = q.hold_req;
            end
            default:
            begin
               d.rdata = 32'h0000_0000;
            end
         endcase
      end
      if (wr_ok)
      begin
         case (AVS_ADDRESS)
            dps_pkg::REG_TXD:  d.txd      = AVS_WRITEDATA[7:0];
            dps_pkg::REG_HOLD: d.hold_req = AVS_WRITEDATA[0];
            default:           d.hold_req = q.hold_req;
         endcase
      end
      d.div = tick ? 5'h00 : q.div + 5'h01;
      case (q.st)
         dps_pkg::H_IDLE:
         begin
            d.div = 5'h00;
            if (wr_ok && AVS_ADDRESS == dps_pkg::REG_CMD)
            begin
               d.addr = AVS_WRITEDATA[dps_pkg::CMD_ADDR_LSB +: 4];
               d.op   = AVS_WRITEDATA[dps_pkg::CMD_OP_LSB +: 4];
               d.sel  = AVS_WRITEDATA[dps_pkg::CMD_SEL_LSB +: 2];
               d.pot  = AVS_WRITEDATA[dps_pkg::CMD_POT_BIT];
               d.sh   = {dps_pkg::DEV_TYPE, AVS_WRITEDATA[dps_pkg::CMD_ADDR_LSB +: 4],
                         AVS_WRITEDATA[dps_pkg::CMD_OP_LSB +: 4],
                         AVS_WRITEDATA[dps_pkg::CMD_SEL_LSB +: 2], 1'b0,
                         AVS_WRITEDATA[dps_pkg::CMD_POT_BIT], q.txd}; // [R17] [R18]
               d.mosi = dps_pkg::DEV_TYPE[3]; // [R2]
               d.cs_b = 1'b0; // [R12]
               d.bitn = 5'h00;
               d.st   = dps_pkg::H_SETUP;
            end
         end
         dps_pkg::H_SETUP:
         begin
            if (tick)
            begin
               d.st = dps_pkg::H_RUN;
            end
         end
         dps_pkg::H_RUN:
         begin
            if (tick && !q.sck)
            begin
               // hold moves only while the clock rests low
               if (q.hold_req)
               begin
                  d.hold_b = 1'b0; // [R3]
               end
               else if (!q.hold_b)
               begin
                  d.hold_b = 1'b1; // [R4] [R6]
               end
               else
               begin
                  d.sck = 1'b1;
                  d.rx  = {q.rx[6:0], q.miso_y[1]};
               end
            end
            else if (tick)
            begin
               d.sck  = 1'b0;
               d.sh   = {q.sh[22:0], 1'b0};
               d.mosi = q.sh[22]; // [R2]
               d.bitn = q.bitn + 5'h01;
               if (q.bitn == dps_pkg::BITS_LAST)
               begin
                  d.st = dps_pkg::H_DONE;
               end
            end
         end
         dps_pkg::H_DONE:
         begin
            if (tick)
            begin
               d.cs_b = 1'b1;
               d.st   = dps_pkg::H_GAP;
            end
         end
         dps_pkg::H_GAP:
         begin
            if (tick)
            begin
               d.st = dps_pkg::H_IDLE;
            end
         end
         default:
         begin
            d.st = dps_pkg::H_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         q        <= '0;
         q.st     <= dps_pkg::H_IDLE;
         q.cs_b   <= 1'b1;
         q.hold_b <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign SPI.cs_b     = q.cs_b;
   assign SPI.sck      = q.sck;
   assign SPI.mosi     = q.mosi;
   assign SPI.hold_b   = q.hold_b;
   assign AVS_READDATA = q.rdata;
endmodule
`default_nettype wire

// *** dv/dps_spi_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module dps_spi_monitor #(
   parameter int NV_WRITE_CYC = 50
) (
   input wire logic REF_CLK,       // clock
   input wire logic RST_B,         // reset, active low
   input wire logic cs_b,          // chip select
   input wire logic sck,           // serial clock
   input wire logic mosi,          // master data
   input wire logic hold_b,        // pause
   input wire logic miso,          // device data
   input wire logic miso_oe_b,     // device drive enable
   input wire logic miso_line,     // resolved wire
   input wire logic NV_WRITE_BUSY, // write busy
   input wire logic STANDBY        // standby state
);
   logic [31:0] busy_cnt_q;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);

   ////////////////////////////////////////////////////////////////
   // length of each busy period, checked when it ends
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
         busy_cnt_q <= 32'h0;
      else
         busy_cnt_q <= NV_WRITE_BUSY ? busy_cnt_q + 32'h1 : 32'h0;
   end

   ////////////////////////////////////////////////////////////////
   chk_deselect_release: assert property (cs_b [*5] |-> miso_oe_b)
      else $error("output driven while deselected");
   chk_miso_on_low: assert property (!miso_oe_b && $changed(miso) |-> !sck)
      else $error("output changed while clock high");
   chk_mosi_steady: assert property (sck |-> $stable(mosi))
      else $error("input moved while clock high");
   chk_hold_clk_low: assert property ($changed(hold_b) |-> !sck)
      else $error("pause toggled while clock high");
   chk_hold_release: assert property (!hold_b [*5] |-> miso_oe_b)
      else $error("output driven while paused");
   chk_busy_awake: assert property (NV_WRITE_BUSY |-> !STANDBY)
      else $error("standby during write cycle");
   chk_select_awake: assert property (!cs_b [*5] |-> !STANDBY)
      else $error("standby while selected");
   chk_select_fall: assert property ($fell(cs_b) |-> !sck && hold_b)
      else $error("select fell with clock high");
   chk_busy_length: assert property ($fell(NV_WRITE_BUSY) |->
      busy_cnt_q + 1 >= NV_WRITE_CYC && busy_cnt_q <= NV_WRITE_CYC + 1)
      else $error("write cycle length wrong");

   cov_busy: cover property ($rose(NV_WRITE_BUSY));
   cov_read_zero: cover property (!miso_oe_b && !miso_line);
   cov_pause: cover property (!cs_b && !hold_b);
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int NV_CYC = 50;
   logic            ref_clk = 1'b0;
   logic            rst_b;
   logic            strap0;
   logic            strap1;
   logic            wp_b;
   logic [3:0]      av_addr;
   logic            av_read;
   logic            av_write;
   logic [31:0]     av_wdata;
   logic [31:0]     av_rdata;
   logic            av_wait;
   logic [1:0][7:0] wiper_pos;
   logic            nv_busy;
   logic            standby;
   int              busy_cyc = 0;
   int              b0;
   logic [7:0]      wip_m [2];
   logic [7:0]      v;
   logic [7:0]      rx;
   logic [3:0]      adr;
   logic [31:0]     st;
   int              n_errors;
   int              check_count;
   int              i;

   dps_spi_if dps_spi_if_i ();
   dps_host dps_host_i (.REF_CLK(ref_clk), .RST_B(rst_b), .SPI(dps_spi_if_i),
      .AVS_ADDRESS(av_addr), .AVS_READ(av_read), .AVS_WRITE(av_write),
      .AVS_WRITEDATA(av_wdata), .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait));
   dps_device #(.NV_WRITE_CYC(NV_CYC)) dps_device_i (.REF_CLK(ref_clk), .RST_B(rst_b),
      .SPI(dps_spi_if_i), .SLAVE_ADDR_STRAP_0(strap0), .SLAVE_ADDR_STRAP_1(strap1),
      .WP_B(wp_b), .WIPER_POS(wiper_pos), .NV_WRITE_BUSY(nv_busy), .STANDBY(standby));
   dps_spi_monitor #(.NV_WRITE_CYC(NV_CYC)) dps_spi_monitor_i (.REF_CLK(ref_clk),
      .RST_B(rst_b), .cs_b(dps_spi_if_i.cs_b), .sck(dps_spi_if_i.sck),
      .mosi(dps_spi_if_i.mosi), .hold_b(dps_spi_if_i.hold_b), .miso(dps_spi_if_i.miso),
      .miso_oe_b(dps_spi_if_i.miso_oe_b), .miso_line(dps_spi_if_i.miso_line),
      .NV_WRITE_BUSY(nv_busy), .STANDBY(standby));

   ////////////////////////////////////////////////////////////////
   always #2.5 ref_clk = ~ref_clk;

   // busy cycles are counted between edges, where the flag is settled
   always @(negedge ref_clk)
   begin
      if (nv_busy === 1'b1)
         busy_cyc <= busy_cyc + 1;
   end

   ////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      logic w;
      @(posedge ref_clk);
      av_addr <= a;
      av_wdata <= d;
      av_read <= rd;
      av_write <= !rd;
      do
      begin
         // look between edges: the value seen is the one the next edge samples
         @(negedge ref_clk);
         w = av_wait;
         q = av_rdata;
         @(posedge ref_clk);
      end
      while (w !== 1'b0);
      av_read <= 1'b0;
      av_write <= 1'b0;
   endtask

   task automatic wait_idle(output logic [7:0] r);
      logic [31:0] s;
      do
         bus(1'b1, dps_pkg::REG_STATUS, 32'h0, s);
      while (s[0] !== 1'b0);
      r = s[15:8];
   endtask

   task automatic frame(input logic [3:0] op, input logic [1:0] sel, input logic pot,
                        input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
      logic [31:0] q;
      bus(1'b0, dps_pkg::REG_TXD, {24'h0, d}, q);
      bus(1'b0, dps_pkg::REG_CMD, {17'h0, pot, sel, op, 4'h0, a}, q);
      wait_idle(r);
   endtask

   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (80000) @(posedge ref_clk);
      n_errors++;
      test_done();
   end

   initial
   begin
      rst_b = 1'b0;
      wp_b = 1'b1;
      av_addr = 4'h0;
      av_read = 1'b0;
      av_write = 1'b0;
      av_wdata = 32'h0;
      n_errors = 0;
      check_count = 0;
      void'($urandom(32'h9DBC97E2));
      {strap1, strap0} = 2'($urandom);
      adr = {2'b00, strap1, strap0};
      wip_m[0] = dps_pkg::DATA_RESET;
      wip_m[1] = dps_pkg::DATA_RESET;
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(32'(wiper_pos), 32'h8080);
      chk(32'(standby), 32'h1);
      for (i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
         frame(dps_pkg::OP_WR_WIPER, 2'h0, i[0], adr, v, rx);
         wip_m[i[0]] = v;
         chk(32'(wiper_pos), {16'h0, wip_m[1], wip_m[0]});
         frame(dps_pkg::OP_RD_WIPER, 2'h0, i[0], adr, 8'h00, rx);
         chk(32'(rx), 32'(v));
      end
      for (i = 0; i < 4; i++)
      begin
         frame(dps_pkg::OP_WR_WIPER, 2'h0, 1'b0, adr ^ (4'h1 << i), ~wip_m[0], rx);
         chk(32'(wiper_pos), {16'h0, wip_m[1], wip_m[0]});
         frame(dps_pkg::OP_RD_WIPER, 2'h0, 1'b0, adr ^ (4'h1 << i), 8'h00, rx);
         chk(32'(rx), 32'hFF);
      end
      for (i = 0; i < 8; i++)
      begin
         v = 8'($urandom);
         b0 = busy_cyc;
         frame(dps_pkg::OP_WR_DATA, i[2:1], i[0], adr, v, rx);
         // the write cycle outlasts the frame tail: let it finish first
         repeat (NV_CYC) @(posedge ref_clk);
         chk(32'(busy_cyc - b0), 32'(NV_CYC));
         if (i == 7)
         begin
            wp_b <= 1'b0;
            b0 = busy_cyc;
            frame(dps_pkg::OP_WR_DATA, i[2:1], i[0], adr, ~v, rx);
            repeat (NV_CYC) @(posedge ref_clk);
            chk(32'(busy_cyc - b0), 32'h0);
            wp_b <= 1'b1;
         end
         frame(dps_pkg::OP_RD_DATA, i[2:1], i[0], adr, 8'h00, rx);
         chk(32'(rx), 32'(v));
      end
      frame(dps_pkg::OP_RD_STATUS, 2'h0, 1'b0, adr, 8'h00, rx);
      chk(32'(rx), 32'h0);
      // pause in the middle of the returned byte, then resume
      bus(1'b0, dps_pkg::REG_TXD, 32'h0, st);
      bus(1'b0, dps_pkg::REG_CMD, {20'h0, dps_pkg::OP_RD_WIPER, 4'h0, adr}, st);
      repeat (650) @(posedge ref_clk);
      bus(1'b0, dps_pkg::REG_HOLD, 32'h1, st);
      repeat (200) @(posedge ref_clk);
      bus(1'b1, dps_pkg::REG_STATUS, 32'h0, st);
      chk(st & 32'h3, 32'h3);
      bus(1'b0, dps_pkg::REG_HOLD, 32'h0, st);
      wait_idle(rx);
      chk(32'(rx), 32'(wip_m[0]));
      chk(32'(dps_spi_if_i.hold_b), 32'h1);
      // second power-up in mid-run recalls the default register
      rst_b <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(32'(wiper_pos), 32'h8080);
      frame(dps_pkg::OP_WR_WIPER, 2'h0, 1'b1, adr, 8'h3C, rx);
      chk(32'(wiper_pos), 32'h3C80);
      test_done();
   end
endmodule
`default_nettype wire
